/* hw/asp_pkg.sv */
// Shared constants, types and helpers of the serial port
`default_nettype none
package asp_pkg;
    localparam int DATA_W = 9;
    localparam int RELOAD_W = 13;
    localparam int FRAC_W = 9;
    localparam int ABD_W = 17;
    localparam int OVS_SHIFT = 4;
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 8;
    localparam int IRDA_W = 8;
    // Oversampling: 16 ticks per async bit, 8 ticks per sync bit
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] SYNC_LAST = 4'h7;
    localparam logic [3:0] SYNC_RISE = 4'h4;
    // Fixed IrDA pulse: 3 of 16 ticks
    localparam logic [3:0] IRDA_FIXED = 4'h3;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_ASYNC8 = 2'h1;
    localparam logic [1:0] MODE_ASYNC9 = 2'h2;
    localparam logic [1:0] MODE_WAKE = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_START = 2'h1,
        ST_DATA = 2'h3,
        ST_STOP = 2'h2
    } asp_state_t;

    typedef enum logic [1:0] {
        ABD_WAIT = 2'h0,
        ABD_MEAS = 2'h1,
        ABD_DONE = 2'h3
    } asp_abd_t;

    function automatic logic [3:0] asp_frame_bits(input logic [1:0] mode);
        return (mode == MODE_ASYNC9 || mode == MODE_WAKE) ? BITS_9 : BITS_8;
    endfunction

    // Parity over all frame bits below the parity position
    function automatic logic asp_parity(input logic [DATA_W-1:0] dat,
                                        input logic [3:0] nbits,
                                        input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < DATA_W - 1; i++) begin
            if (4'(i) < nbits - 4'h1) begin
                p = p ^ dat[i];
            end
        end
        return p;
    endfunction
endpackage
`default_nettype wire

/* hw/asp_fifo.sv */
// Flop-based FIFO with registered outputs
`timescale 1ns/10ps
`default_nettype none
module asp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    import asp_pkg::*;
    localparam int AW = $clog2(DEPTH);

    // Storage keeps DEPTH-1 words; the output stage is the last slot
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic full;
        logic rdy;
        logic ov;
        logic [WIDTH-1:0] od;
    } asp_fifo_st_t;

    asp_fifo_st_t q, d;
    logic push, take;

    always_comb begin
        d = q;
        push = in_valid && !q.full;
        take = (q.cnt != '0) && (!q.ov || out_ready);
        if (q.ov && out_ready) begin
            d.ov = 1'b0;
        end
        if (take) begin
            d.od = q.mem[q.rd];
            d.ov = 1'b1;
            d.rd = q.rd + 1'b1;
        end
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = q.wr + 1'b1;
        end
        d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
        d.full = (d.cnt == (AW+1)'(DEPTH - 1));
        d.rdy = !d.full;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready = q.rdy;
    assign out_valid = q.ov;
    assign out_data = q.od;

    chk_fifo_hold_full: assert property (@(posedge clk) disable iff (sys_rst)
        q.full && !take |=> q.wr == $past(q.wr) && q.full)
        else $error("write pointer moved while buffer full");
endmodule
`default_nettype wire

/* hw/asp_top.sv */
// Asynchronous/synchronous serial port core
//
// Function
// - Full-duplex async, half-duplex sync operation
// - Start bit, 8/9 data bits, 1-2 stops
// - Wake bit separates address from data
// - IrDA encoding with fixed or programmed pulse
// - Sync mode drives clock, 8-bit characters
// - Least significant bit always shifted first
// - Eight-character FIFO in each direction
// - Fractional divider produces standard rates
// - Async rate range set by divider
// - Sync rate range set by divider
// - Autobaud measures start bit, loads baud setting
// - Parity generated on send, checked on receive
// - Missing stop bit flags framing error
// - Full receive buffer flags overrun error
// - Loop-back routes transmit into receiver
// - Five request outputs for port events
`timescale 1ns/10ps
`default_nettype none
module asp_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_parity_en,
    input wire logic cfg_parity_odd,
    input wire logic cfg_two_stop,
    input wire logic cfg_loopback,
    input wire logic cfg_irda_en,
    input wire logic cfg_irda_prog,
    input wire logic [asp_pkg::IRDA_W-1:0] cfg_irda_width,
    input wire logic [asp_pkg::RELOAD_W-1:0] cfg_reload,
    input wire logic [asp_pkg::FRAC_W-1:0] cfg_frac,
    input wire logic cfg_rx_en,
    input wire logic cfg_wake_filter,
    input wire logic cfg_abd_en,
    input wire logic err_clr,
    // Transmit data
    input wire logic tx_valid,
    input wire logic [asp_pkg::DATA_W-1:0] tx_data,
    output logic tx_ready,
    // Receive data
    output logic rx_valid,
    output logic [asp_pkg::DATA_W-1:0] rx_data,
    input wire logic rx_ready,
    // Serial pins
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe,
    output logic txd_o,
    // Status
    output logic err_parity,
    output logic err_frame,
    output logic err_overrun,
    output logic abd_done,
    output logic [asp_pkg::RELOAD_W-1:0] abd_reload,
    // Requests
    output logic irq_tx_empty,
    output logic irq_tx_done,
    output logic irq_rx,
    output logic irq_err,
    output logic irq_abd
);
    import asp_pkg::*;

    typedef struct packed {
        logic [FRAC_W-1:0] acc;
        logic [RELOAD_W-1:0] div;
        logic tick;
        asp_state_t tx_st;
        logic [3:0] tx_ovs;
        logic [3:0] tx_bit;
        logic [DATA_W-1:0] tx_sh;
        logic tx_lv;
        logic [IRDA_W-1:0] pw;
        logic txd;
        logic sclk;
        logic rxd_o;
        logic rxd_oe;
        logic sy_rx;
        logic [7:0] sy_in;
        asp_state_t rx_st;
        logic [3:0] rx_ovs;
        logic [3:0] rx_bit;
        logic [DATA_W-1:0] rx_sh;
        logic rx_prev;
        logic [3:0] irc;
        logic rxf_v;
        logic [DATA_W-1:0] rxf_d;
        logic e_par;
        logic e_frm;
        logic e_ovr;
        logic irq_txe;
        logic irq_txd;
        logic irq_rx;
        logic irq_err;
        logic irq_abd;
        asp_abd_t abd_st;
        logic abd_done;
        logic abd_prev;
        logic [ABD_W-1:0] abd_cnt;
        logic [RELOAD_W-1:0] abd_rl;
    } asp_top_st_t;

    asp_top_st_t q, d;
    logic [1:0] mode_eff;
    logic sync, par_on;
    logic [3:0] nb;
    logic [RELOAD_W-1:0] reload_eff;
    logic [FRAC_W-1:0] frac_eff;
    logic [FRAC_W:0] acc_sum;
    logic pre, newbit, pulse, din, raw, line, fall, rx_done;
    logic set_par, set_frm, set_ovr, pop, tx_out_valid, rx_in_ready;
    logic [DATA_W-1:0] tx_out_data, rx_w;

    // ****************************************************************
    // Buffers
    // ****************************************************************
    asp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(tx_valid),
        .in_data(tx_data),
        .in_ready(tx_ready),
        .out_valid(tx_out_valid),
        .out_data(tx_out_data),
        .out_ready(pop)
    );

    asp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(q.rxf_v),
        .in_data(q.rxf_d),
        .in_ready(rx_in_ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );

    // ****************************************************************
    // Mode and line decode
    // ****************************************************************
    // Autobaud result overrides rate and forces 8-bit async framing
    assign mode_eff = q.abd_done ? MODE_ASYNC8 : cfg_mode;
    assign sync = (mode_eff == MODE_SYNC);
    assign par_on = cfg_parity_en && !sync && (mode_eff != MODE_WAKE);
    assign nb = asp_frame_bits(mode_eff);
    assign reload_eff = q.abd_done ? q.abd_rl : cfg_reload;
    assign frac_eff = q.abd_done ? '0 : cfg_frac;
    assign acc_sum = {1'b0, q.acc} + {1'b0, frac_eff};
    // Zero fraction bypasses the fractional stage
    assign pre = (frac_eff == '0) || acc_sum[FRAC_W];
    assign din = cfg_loopback ? q.rxd_o : rxd_i;
    assign raw = cfg_loopback ? q.tx_lv : rxd_i;
    // Loop-back carries the plain bit, so no pulse decode there
    assign line = (cfg_irda_en && !cfg_loopback) ? (raw && q.irc == '0)
                                                 : raw;
    assign fall = q.rx_prev && !line;
    assign rx_w = (nb == BITS_9) ? q.rx_sh : {1'b0, q.rx_sh[DATA_W-1:1]};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        pop = 1'b0;
        newbit = 1'b0;
        rx_done = 1'b0;
        set_par = 1'b0;
        set_frm = 1'b0;
        set_ovr = 1'b0;
        d.tick = 1'b0;
        d.rxf_v = 1'b0;
        d.irq_txe = 1'b0;
        d.irq_txd = 1'b0;
        d.irq_rx = 1'b0;
        d.irq_abd = 1'b0;
        d.acc = acc_sum[FRAC_W-1:0];
        if (pre) begin
            if (q.div == '0) begin
                d.div = reload_eff;
                d.tick = 1'b1;
            end else begin
                d.div = q.div - 1'b1;
            end
        end

        unique case (q.tx_st)
            ST_IDLE: begin
                d.tx_lv = 1'b1;
                d.sclk = 1'b1;
                d.rxd_oe = 1'b0;
                d.tx_ovs = '0;
                d.tx_bit = '0;
                if (tx_out_valid) begin
                    pop = 1'b1;
                    newbit = 1'b1;
                    d.irq_txe = 1'b1;
                    d.sy_rx = 1'b0;
                    d.tx_sh = tx_out_data;
                    if (par_on) begin
                        d.tx_sh[nb - 4'h1] = asp_parity(tx_out_data, nb,
                                                        cfg_parity_odd);
                    end
                    if (sync) begin
                        d.tx_st = ST_DATA;
                        d.sclk = 1'b0;
                        d.rxd_oe = 1'b1;
                        d.rxd_o = tx_out_data[0];
                    end else begin
                        d.tx_st = ST_START;
                        d.tx_lv = 1'b0;
                    end
                end else if (sync && cfg_rx_en) begin
                    d.tx_st = ST_DATA;
                    d.sclk = 1'b0;
                    d.sy_rx = 1'b1;
                    d.tx_sh = '1;
                end
            end
            ST_START: if (q.tick) begin
                if (q.tx_ovs == OVS_LAST) begin
                    d.tx_ovs = '0;
                    d.tx_st = ST_DATA;
                    d.tx_lv = q.tx_sh[0];
                    newbit = 1'b1;
                end else begin
                    d.tx_ovs = q.tx_ovs + 4'h1;
                end
            end
            ST_DATA: if (q.tick) begin
                if (sync && q.tx_ovs == SYNC_LAST) begin
                    d.tx_ovs = '0;
                    d.sclk = 1'b0;
                    d.tx_sh = q.tx_sh >> 1;
                    d.rxd_o = q.tx_sh[1];
                    if (q.tx_bit == BITS_8 - 4'h1) begin
                        d.tx_st = ST_IDLE;
                        d.sclk = 1'b1;
                        d.rxd_oe = 1'b0;
                        d.rxf_v = q.sy_rx || cfg_loopback;
                        d.rxf_d = {1'b0, q.sy_in};
                        d.irq_rx = d.rxf_v;
                        d.irq_txd = !q.sy_rx;
                        set_ovr = d.rxf_v && !rx_in_ready;
                    end else begin
                        d.tx_bit = q.tx_bit + 4'h1;
                    end
                end else if (sync) begin
                    d.tx_ovs = q.tx_ovs + 4'h1;
                    d.sclk = (d.tx_ovs >= SYNC_RISE);
                    if (d.tx_ovs == SYNC_RISE) begin
                        d.sy_in = {din, q.sy_in[7:1]};
                    end
                end else if (q.tx_ovs == OVS_LAST) begin
                    d.tx_ovs = '0;
                    newbit = 1'b1;
                    if (q.tx_bit == nb - 4'h1) begin
                        d.tx_st = ST_STOP;
                        d.tx_bit = '0;
                        d.tx_lv = 1'b1;
                    end else begin
                        d.tx_bit = q.tx_bit + 4'h1;
                        d.tx_sh = q.tx_sh >> 1;
                        d.tx_lv = q.tx_sh[1];
                    end
                end else begin
                    d.tx_ovs = q.tx_ovs + 4'h1;
                end
            end
            ST_STOP: if (q.tick) begin
                if (q.tx_ovs == OVS_LAST) begin
                    d.tx_ovs = '0;
                    newbit = 1'b1;
                    if (q.tx_bit != '0 || !cfg_two_stop) begin
                        d.tx_st = ST_IDLE;
                        d.irq_txd = 1'b1;
                    end else begin
                        d.tx_bit = 4'h1;
                    end
                end else begin
                    d.tx_ovs = q.tx_ovs + 4'h1;
                end
            end
        endcase

        // A zero bit goes out as one short low pulse
        d.pw = newbit ? '0 : ((q.pw == '1) ? q.pw : q.pw + 1'b1);
        pulse = cfg_irda_prog ? (d.pw < cfg_irda_width)
                              : (d.tx_ovs < IRDA_FIXED);
        d.txd = sync ? d.sclk
                     : (cfg_irda_en ? !(!d.tx_lv && pulse) : d.tx_lv);

        // Stretch an IrDA low pulse over roughly one bit
        if (!raw) begin
            d.irc = OVS_LAST;
        end else if (q.tick && q.irc != '0) begin
            d.irc = q.irc - 4'h1;
        end
        d.rx_prev = line;

        unique case (q.rx_st)
            ST_IDLE: if (fall && cfg_rx_en && !sync) begin
                d.rx_st = ST_START;
                d.rx_ovs = '0;
            end
            ST_START: if (q.tick) begin
                if (q.rx_ovs == OVS_MID) begin
                    d.rx_ovs = '0;
                    d.rx_bit = '0;
                    // A start bit that is high again at mid-bit was a glitch
                    d.rx_st = line ? ST_IDLE : ST_DATA;
                end else begin
                    d.rx_ovs = q.rx_ovs + 4'h1;
                end
            end
            ST_DATA: if (q.tick) begin
                if (q.rx_ovs == OVS_LAST) begin
                    d.rx_ovs = '0;
                    d.rx_sh = {line, q.rx_sh[DATA_W-1:1]};
                    if (q.rx_bit == nb - 4'h1) begin
                        d.rx_st = ST_STOP;
                    end else begin
                        d.rx_bit = q.rx_bit + 4'h1;
                    end
                end else begin
                    d.rx_ovs = q.rx_ovs + 4'h1;
                end
            end
            ST_STOP: if (q.tick) begin
                if (q.rx_ovs == OVS_LAST) begin
                    d.rx_st = ST_IDLE;
                    d.rx_ovs = '0;
                    rx_done = 1'b1;
                end else begin
                    d.rx_ovs = q.rx_ovs + 4'h1;
                end
            end
        endcase

        if (rx_done) begin
            set_frm = !line;
            set_par = par_on && (rx_w[nb - 4'h1] !=
                      asp_parity(rx_w, nb, cfg_parity_odd));
            // Address filter drops data characters while waiting
            if (!(cfg_wake_filter && mode_eff == MODE_WAKE &&
                  !rx_w[DATA_W-1])) begin
                d.rxf_v = 1'b1;
                d.rxf_d = rx_w;
                d.irq_rx = 1'b1;
                set_ovr = !rx_in_ready;
            end
        end
        // Set wins over a clear in the same cycle
        d.e_par = set_par || (q.e_par && !err_clr);
        d.e_frm = set_frm || (q.e_frm && !err_clr);
        d.e_ovr = set_ovr || (q.e_ovr && !err_clr);
        d.irq_err = set_par || set_frm || set_ovr;

        // Autobaud: start bit length gives sixteen ticks of one bit
        d.abd_prev = rxd_i;
        unique case (q.abd_st)
            ABD_WAIT: if (cfg_abd_en && q.abd_prev && !rxd_i) begin
                d.abd_st = ABD_MEAS;
                d.abd_cnt = ABD_W'(1'b1); // Detection cycle is already low
                d.irq_abd = 1'b1;
            end
            ABD_MEAS: begin
                if (q.abd_cnt != '1) begin
                    d.abd_cnt = q.abd_cnt + 1'b1;
                end
                if (rxd_i) begin
                    d.abd_st = ABD_DONE;
                    d.abd_done = 1'b1;
                    d.irq_abd = 1'b1;
                    d.abd_rl = (q.abd_cnt[ABD_W-1:OVS_SHIFT] == '0) ? '0
                             : q.abd_cnt[ABD_W-1:OVS_SHIFT] - 1'b1;
                end
            end
            ABD_DONE: if (!cfg_abd_en) begin
                d.abd_st = ABD_WAIT;
                d.abd_done = 1'b0;
            end
            default: d.abd_st = ABD_WAIT;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.tx_lv <= 1'b1;
            q.txd <= 1'b1;
            q.sclk <= 1'b1;
            q.rx_prev <= 1'b1;
            q.abd_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign txd_o = q.txd;
    assign rxd_o = q.rxd_o;
    assign rxd_oe = q.rxd_oe;
    assign err_parity = q.e_par;
    assign err_frame = q.e_frm;
    assign err_overrun = q.e_ovr;
    assign abd_done = q.abd_done;
    assign abd_reload = q.abd_rl;
    assign irq_tx_empty = q.irq_txe;
    assign irq_tx_done = q.irq_txd;
    assign irq_rx = q.irq_rx;
    assign irq_err = q.irq_err;
    assign irq_abd = q.irq_abd;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_sync_drive_only: assert property (@(posedge clk)
        disable iff (sys_rst) rxd_oe |-> q.tx_st == ST_DATA && !q.sy_rx)
        else $error("data pin driven outside a sync send");
    chk_tx_start_low: assert property (@(posedge clk)
        disable iff (sys_rst)
        q.tx_st == ST_IDLE && tx_out_valid && !sync && !cfg_irda_en
        |=> !txd_o && q.tx_st == ST_START)
        else $error("start bit not low");
    chk_tx_stop_high: assert property (@(posedge clk)
        disable iff (sys_rst) q.tx_st == ST_STOP |-> q.tx_lv)
        else $error("stop bit not high");
    chk_sync_lsb_first: assert property (@(posedge clk)
        disable iff (sys_rst)
        q.tx_st == ST_IDLE && tx_out_valid && sync
        |=> rxd_oe && rxd_o == $past(tx_out_data[0]))
        else $error("sync send did not begin with bit 0");
    chk_irda_idle_high: assert property (@(posedge clk)
        disable iff (sys_rst)
        q.tx_st == ST_IDLE && !tx_out_valid && cfg_irda_en && !sync
        |=> txd_o)
        else $error("IrDA line not high when idle");
    chk_tick_spacing: assert property (@(posedge clk)
        disable iff (sys_rst)
        q.tick && reload_eff != '0 && $stable(reload_eff) |=> !q.tick)
        else $error("baud ticks closer than the reload allows");
    chk_frame_flag: assert property (@(posedge clk)
        disable iff (sys_rst) rx_done && !line |=> err_frame && irq_err)
        else $error("missing stop bit not flagged");
    chk_overrun_flag: assert property (@(posedge clk)
        disable iff (sys_rst) d.rxf_v && !rx_in_ready |=> err_overrun)
        else $error("overrun not flagged");
    chk_abd_requests: assert property (@(posedge clk)
        disable iff (sys_rst)
        q.abd_st == ABD_MEAS ##1 q.abd_st == ABD_DONE |-> irq_abd)
        else $error("autobaud end request missing");
endmodule
`default_nettype wire

/* tb/asp_term.sv */
// Terminal model on the port's async lines
`timescale 1ns/10ps
`default_nettype none
module asp_term (
    // Clock
    input wire logic clk,
    // Lines
    input wire logic line_in,
    output logic line_out,
    // Frame bits and bit time in clocks
    input wire logic [3:0] nbits,
    input wire logic [5:0] blen
);
    logic [8:0] got[$];
    logic [8:0] v;
    initial line_out = 1'b1;
    task automatic send(input logic [8:0] d, input logic stp);
        line_out <= 1'b0;
        repeat (blen) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            line_out <= d[i];
            repeat (blen) @(posedge clk);
        end
        line_out <= stp;
        repeat (blen) @(posedge clk);
        line_out <= 1'b1;
        repeat (blen) @(posedge clk);
    endtask
    // Mid-bit sampling; stop level is not judged here
    always begin
        @(negedge line_in);
        repeat (blen / 2) @(posedge clk);
        v = 9'h000;
        for (int i = 0; i < nbits; i++) begin
            repeat (blen) @(posedge clk);
            v[i] = line_in;
        end
        got.push_back(v);
        repeat (blen) @(posedge clk);
    end
endmodule
`default_nettype wire

/* tb/test_async_sync_serial_port.sv */
// Bench of the serial port against a queue model
`timescale 1ns/10ps
`default_nettype none
module test_async_sync_serial_port;
    import asp_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, tx_valid = 1'b0, rx_ready = 1'b1;
    logic par_en = 1'b0, par_odd = 1'b0, two_stop = 1'b0, loop = 1'b0;
    logic wake = 1'b0, err_clr = 1'b0, rx_en = 1'b1, irda = 1'b0, abd = 1'b0;
    logic tx_ready, rx_valid, txd_o, rx_line, e_par, e_frm, e_ovr, irq_txd;
    logic [1:0] mode = MODE_ASYNC8;
    logic [3:0] nb = BITS_8;
    logic [5:0] blen = 6'h10;
    logic [12:0] rel = 13'h0000, abd_rl;
    logic [8:0] tx_data = 9'h000, rx_data, v, frac = 9'h000;
    logic [8:0] exp_q[$], txq[$];
    int err_count = 0, num_checks = 0, cyc = 0, ndone = 0;
    asp_top asp_top_inst (.clk(clk), .sys_rst(sys_rst), .cfg_mode(mode),
        .cfg_parity_en(par_en), .cfg_parity_odd(par_odd),
        .cfg_two_stop(two_stop), .cfg_loopback(loop), .cfg_irda_en(irda),
        .cfg_irda_prog(1'b0), .cfg_irda_width(8'h00), .cfg_reload(rel),
        .cfg_frac(frac), .cfg_rx_en(rx_en), .cfg_wake_filter(wake),
        .cfg_abd_en(abd), .err_clr(err_clr), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .rxd_i(rx_line),
        .rxd_o(), .rxd_oe(), .txd_o(txd_o), .err_parity(e_par),
        .err_frame(e_frm), .err_overrun(e_ovr), .abd_done(),
        .abd_reload(abd_rl), .irq_tx_empty(), .irq_tx_done(irq_txd),
        .irq_rx(), .irq_err(), .irq_abd());
    asp_term asp_term_inst (.clk(clk), .line_in(txd_o),
        .line_out(rx_line), .nbits(nb), .blen(blen));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic check(input string n, input logic [8:0] s,
                         input logic [8:0] w);
        num_checks++;
        if (s !== w) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, w, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Popped characters must match the model in order
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq_txd === 1'b1) ndone <= ndone + 1;
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0) check("rx_extra", 9'h001, 9'h000);
            else check("rx_data", rx_data, exp_q.pop_front());
        end
        if (cyc == 40000) begin
            err_count++;
            final_report();
        end
    end
    function automatic logic [8:0] msk(input logic [8:0] d);
        return d & ((9'h001 << nb) - 9'h001);
    endfunction
    task automatic push(input logic [8:0] d);
        tx_valid <= 1'b1;
        tx_data <= d;
        do @(posedge clk); while (tx_ready !== 1'b1);
    endtask
    task automatic tx_run(input int n);
        int d0;
        @(posedge clk);
        d0 = ndone;
        asp_term_inst.got.delete();
        for (int i = 0; i < n; i++) begin
            v = msk(9'($urandom));
            if (par_en) v[7] = par_odd ^ (^v[6:0]);
            txq.push_back(v);
            push(9'($urandom) & 9'h100 | v);
        end
        tx_valid <= 1'b0;
        for (int k = 0; k < 9000 && asp_term_inst.got.size() < n; k++)
            @(posedge clk);
        repeat (4 * blen) @(posedge clk);
        check("tx_count", 9'(asp_term_inst.got.size()), 9'(n));
        check("tx_done", 9'(ndone - d0), 9'(n));
        while (txq.size() > 0)
            check("tx_char", asp_term_inst.got.pop_front(),
                  txq.pop_front());
    endtask
    task automatic rx_send(input logic [8:0] d, input logic stp,
                           input logic keep);
        @(posedge clk);
        if (keep) exp_q.push_back(msk(d));
        asp_term_inst.send(d, stp);
    endtask
    task automatic clear_wait();
        err_clr <= 1'b1;
        @(posedge clk);
        err_clr <= 1'b0;
        for (int k = 0; k < 900 && exp_q.size() > 0; k++)
            @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        void'($urandom(11710));
        repeat (2) @(posedge clk);
        tx_run(10);
        $display("test tx done");
        // Slower divider and two stops alongside odd parity
        rel <= 13'h0001;
        blen <= 6'h20;
        two_stop <= 1'b1;
        par_en <= 1'b1;
        par_odd <= 1'b1;
        tx_run(4);
        // Half-rate prescale from the fraction instead of the reload
        rel <= 13'h0000;
        frac <= 9'h100;
        par_odd <= 1'b0;
        tx_run(4);
        rx_send(9'h001, 1'b1, 1'b1);
        check("err_parity", {8'h00, e_par}, 9'h001);
        clear_wait();
        abd <= 1'b1;
        rx_send(9'h0ff, 1'b1, 1'b1);
        // Start bit of 32 clocks means a reload of one
        check("abd_reload", 9'(abd_rl), 9'h001);
        clear_wait();
        abd <= 1'b0;
        frac <= 9'h000;
        blen <= 6'h10;
        $display("test parity done");
        par_en <= 1'b0;
        two_stop <= 1'b0;
        for (int i = 0; i < 4; i++) rx_send(9'($urandom), 1'b1, 1'b1);
        rx_send(9'h0c3, 1'b0, 1'b1);
        check("err_frame", {8'h00, e_frm}, 9'h001);
        clear_wait();
        rx_ready <= 1'b0;
        for (int i = 0; i < 9; i++) rx_send(9'(i + 16), 1'b1, i < 8);
        check("err_overrun", {8'h00, e_ovr}, 9'h001);
        rx_ready <= 1'b1;
        clear_wait();
        $display("test rx done");
        mode <= MODE_WAKE;
        nb <= BITS_9;
        wake <= 1'b1;
        rx_send(9'h0a5, 1'b1, 1'b0);
        rx_send(9'h15a, 1'b1, 1'b1);
        mode <= MODE_ASYNC8;
        nb <= BITS_8;
        loop <= 1'b1;
        irda <= 1'b1;
        @(posedge clk);
        v = 9'($urandom);
        exp_q.push_back(msk(v));
        push(v);
        tx_valid <= 1'b0;
        clear_wait();
        // Sync send looped back; receive-only transfers kept off
        mode <= MODE_SYNC;
        rx_en <= 1'b0;
        @(posedge clk);
        v = 9'($urandom);
        exp_q.push_back(msk(v));
        push(v);
        tx_valid <= 1'b0;
        clear_wait();
        mode <= MODE_ASYNC8;
        loop <= 1'b0;
        irda <= 1'b0;
        rx_send(9'h033, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        check("rx_left", 9'(exp_q.size()), 9'h000);
        $display("test wake and loop done");
        final_report();
    end
endmodule
`default_nettype wire
